// ==== ltb_top.sv ====
// Limit test judgement unit with handler handshake and register slave.
//
// Local design decisions: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
module ltb_top
   import ltb_pkg::*;
(
   // Clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_arst_n,
   // Avalon-MM slave
   input  wire logic [7:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   output logic      [31:0] o_avs_readdata,
   output logic             o_avs_waitrequest,
   // Measurement results
   input  wire logic        i_meas_valid,
   input  wire logic        i_meas_last,
   input  wire logic [31:0] i_amps,
   input  wire logic [31:0] i_coul,
   input  wire logic [31:0] i_volts,
   input  wire logic [31:0] i_ohms,
   input  wire logic [31:0] i_math,
   // Digital I/O port
   input  wire logic [7:0]  i_digital_io_port,
   output logic      [7:0]  o_digital_io_port,
   output logic      [7:0]  o_digital_io_port_oe,
   // Interrupt
   output logic             o_irq
);
   typedef struct packed {
      ltb_state_t              state;
      logic                    waitreq;
      logic [31:0]             rdata;
      logic [31:0]             ctrl;
      logic [31:0]             pins;
      logic [31:0]             diofn;
      logic [31:0]             pass_pat;
      logic [31:0]             fail_pat;
      logic [31:0]             ofs;
      logic [31:0]             istat;
      logic [31:0]             imask;
      logic [NIDX-1:0][31:0]   tcfg;
      logic [NIDX-1:0][31:0]   tup;
      logic [NIDX-1:0][31:0]   tlow;
      logic [31:0]             val;
      logic                    last;
      logic                    seq_open;
      logic                    sot_prev;
      logic                    comp_fail;
      logic [PATW-1:0]         comp_pat;
      logic [PATW-1:0]         pattern;
      logic [3:0]              bin;
      logic                    last_pass;
      logic                    busy_n;
      logic                    test_done_n;
      logic [NPIN-1:0]         dio_out;
      logic [NPIN-1:0]         dio_oe;
      logic                    irq;
   } ltb_regs_t;

   localparam ltb_regs_t REGS_RST = '{state: S_IDLE, waitreq: 1'b1, busy_n: 1'b1,
                                      test_done_n: 1'b1, sot_prev: 1'b1, default: '0};

   ltb_regs_t       q;
   ltb_regs_t       d;
   logic            rst_meta_q;
   logic            rst_n_q;
   logic [NIDX-1:0] en_w;
   logic [NIDX-1:0] above_w;
   logic [NIDX-1:0] below_w;
   logic [NIDX-1:0] inband_w;
   logic [NPIN-1:0] pin_out_w;
   logic [NPIN-1:0] pin_oe_w;
   logic [3:0]      tidx_w;
   logic            tbl_hit_w;
   logic            acc_w;
   logic            clr_w;
   logic            cap_w;
   logic            start_used_w;
   logic            start_request_n;
   logic [31:0]     sel_w;
   logic [31:0]     ofs_term_w;
   logic [2:0]      first_w;
   logic [2:0]      cnt_w;
   logic [2:0]      busy_c_w;
   logic [2:0]      start_c_w;
   logic [2:0]      done_c_w;

   // The reset is released through two stages so every flop leaves reset on the same edge.
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   function automatic logic [31:0] ltb_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be, input logic [31:0] mask);
      logic [31:0] r;
      for (int b = 0; b < 4; b++) begin
         r[b*8 +: 8] = be[b] ? wd[b*8 +: 8] : old[b*8 +: 8];
      end
      return r & mask;
   endfunction : ltb_merge

   assign first_w   = q.pins[P_FIRST +: 3];
   assign cnt_w     = q.pins[P_CNT +: 3];
   assign busy_c_w  = q.pins[P_BUSY +: 3];
   assign start_c_w = q.pins[P_START +: 3];
   assign done_c_w  = q.pins[P_DONE +: 3];
   assign tidx_w    = i_avs_address[7:4] - O_TBL[7:4];
   assign tbl_hit_w = (i_avs_address >= O_TBL) && (tidx_w < 4'(NIDX)) && (i_avs_address[3:2] != 2'h3);
   assign acc_w     = (i_avs_read || i_avs_write) && !q.waitreq;
   assign clr_w     = acc_w && i_avs_write && (i_avs_address == O_CMD) && i_avs_byteenable[0]
                      && i_avs_writedata[K_CLR];

   // A start line on an unassigned or trigger-function pin reads as idle high.
   assign start_used_w    = (start_c_w != 3'h0) && q.diofn[start_c_w];
   assign start_request_n = start_used_w ? i_digital_io_port[start_c_w] : 1'b1;
   assign cap_w = q.ctrl[C_EN] && i_meas_valid
                  && ((q.state == S_WAIT) || ((q.state == S_IDLE) && !start_used_w));

   always_comb begin
      unique case (q.ctrl[C_FEED +: 3])
         F_COUL:  sel_w = i_coul;
         F_VOLT:  sel_w = i_volts;
         F_OHMS:  sel_w = i_ohms;
         F_MATH:  sel_w = i_math;
         default: sel_w = i_amps;
      endcase
   end
   assign ofs_term_w = q.ctrl[C_OFS] ? q.ofs : 32'h0000_0000;

   genvar gi;
   generate
      for (gi = 0; gi < NIDX; gi++) begin : g_cmp
         assign en_w[gi]     = q.tcfg[gi][T_EN];
         assign above_w[gi]  = $signed(q.val) > $signed(q.tup[gi]);
         assign below_w[gi]  = $signed(q.val) < $signed(q.tlow[gi]);
         assign inband_w[gi] = en_w[gi] && !above_w[gi] && !below_w[gi];
      end
      assign pin_out_w[0] = 1'b0;
      assign pin_oe_w[0]  = 1'b0;
      for (gi = 1; gi < NPIN; gi++) begin : g_pin
         logic [2:0] rel;
         logic       is_pat;
         logic       is_busy;
         logic       is_done;
         assign rel     = 3'(gi) - first_w;
         assign is_pat  = (first_w != 3'h0) && (3'(gi) >= first_w) && (rel < cnt_w);
         assign is_busy = busy_c_w == 3'(gi);
         assign is_done = done_c_w == 3'(gi);
         assign pin_oe_w[gi]  = q.diofn[gi] && (is_pat || is_busy || is_done);
         assign pin_out_w[gi] = is_busy ? q.busy_n : is_done ? q.test_done_n
                                : (is_pat && q.pattern[rel]);
      end
   endgenerate

   always_comb begin
      logic            hit;
      logic [3:0]      hidx;
      logic [PATW-1:0] fpat;
      logic [PATW-1:0] tpat;
      logic [31:0]     rd;
      logic [31:0]     w1c;
      logic [31:0]     iset;
      hit  = 1'b0;
      hidx = 4'h0;
      fpat = '0;
      tpat = '0;
      rd   = 32'h0000_0000;
      w1c  = 32'h0000_0000;
      iset = 32'h0000_0000;
      d    = q;

      // One wait state: the answer is given on the cycle after the request shows.
      d.waitreq = 1'b1;
      if ((i_avs_read || i_avs_write) && q.waitreq) begin
         d.waitreq = 1'b0;
         if (tbl_hit_w) begin
            unique case (i_avs_address[3:2])
               TW_UP:   rd = q.tup[tidx_w];
               TW_LOW:  rd = q.tlow[tidx_w];
               default: rd = q.tcfg[tidx_w];
            endcase
         end else begin
            unique case (i_avs_address)
               O_CTRL:  rd = q.ctrl;
               O_PINS:  rd = q.pins;
               O_DIOFN: rd = q.diofn;
               O_PASS:  rd = q.pass_pat;
               O_FAIL:  rd = q.fail_pat;
               O_OFS:   rd = q.ofs;
               O_ISTAT: rd = q.istat;
               O_IMASK: rd = q.imask;
               O_STAT: begin
                  rd[S_BIN +: 4]    = q.bin;
                  rd[S_BUSY]        = !q.busy_n;
                  rd[S_FAIL]        = q.comp_fail;
                  rd[S_PASS]        = q.last_pass;
                  rd[S_PAT +: PATW] = q.pattern;
               end
               default: rd = 32'h0000_0000;
            endcase
         end
         d.rdata = i_avs_read ? rd : 32'h0000_0000;
      end

      if (acc_w && i_avs_write) begin
         if (tbl_hit_w) begin
            unique case (i_avs_address[3:2])
               TW_UP:   d.tup[tidx_w]  = ltb_merge(q.tup[tidx_w], i_avs_writedata, i_avs_byteenable, M_ALL);
               TW_LOW:  d.tlow[tidx_w] = ltb_merge(q.tlow[tidx_w], i_avs_writedata, i_avs_byteenable, M_ALL);
               default: d.tcfg[tidx_w] = ltb_merge(q.tcfg[tidx_w], i_avs_writedata, i_avs_byteenable, M_TCFG);
            endcase
         end else begin
            unique case (i_avs_address)
               O_CTRL:  d.ctrl     = ltb_merge(q.ctrl, i_avs_writedata, i_avs_byteenable, M_CTRL);
               O_PINS:  d.pins     = ltb_merge(q.pins, i_avs_writedata, i_avs_byteenable, M_PINS);
               O_DIOFN: d.diofn    = ltb_merge(q.diofn, i_avs_writedata, i_avs_byteenable, M_DIOFN);
               O_PASS:  d.pass_pat = ltb_merge(q.pass_pat, i_avs_writedata, i_avs_byteenable, M_PAT);
               O_FAIL:  d.fail_pat = ltb_merge(q.fail_pat, i_avs_writedata, i_avs_byteenable, M_PAT);
               O_OFS:   d.ofs      = ltb_merge(q.ofs, i_avs_writedata, i_avs_byteenable, M_ALL);
               O_IMASK: d.imask    = ltb_merge(q.imask, i_avs_writedata, i_avs_byteenable, M_IRQ);
               O_ISTAT: w1c        = ltb_merge(32'h0000_0000, i_avs_writedata, i_avs_byteenable, M_IRQ);
               default: ;
            endcase
         end
      end

      // A clear arriving with a judgement is applied first so the new result survives.
      if (clr_w) begin
         d.comp_fail = 1'b0;
         d.comp_pat  = '0;
         d.pattern   = '0;
      end

      d.sot_prev = start_request_n;
      unique case (q.state)
         S_IDLE: begin
            if (q.ctrl[C_EN] && start_used_w && q.sot_prev && !start_request_n) begin
               d.state  = S_WAIT;
               d.busy_n = 1'b0;
            end
         end
         S_WAIT: begin
            if (!q.ctrl[C_EN]) begin
               d.state  = S_IDLE;
               d.busy_n = 1'b1;
            end
         end
         S_JUDGE: begin
            // The lowest in-band entry wins, and the lowest enabled failing entry gives the fail pattern; scanning downward leaves each last.
            for (int i = NIDX - 1; i >= 0; i--) begin
               if (inband_w[i]) begin
                  hit  = 1'b1;
                  hidx = 4'(i);
               end
               if (en_w[i] && !inband_w[i]) begin
                  fpat = above_w[i] ? q.tcfg[i][T_UPP +: PATW] : q.tcfg[i][T_LOWP +: PATW];
               end
            end
            if (q.ctrl[C_SORT]) begin
               tpat  = hit ? q.tcfg[hidx][T_PASS +: PATW] : q.fail_pat[PATW-1:0];
               d.bin = hit ? (hidx + 4'h1) : BIN_SORT_MISS;
            end else begin
               tpat  = hit ? q.pass_pat[PATW-1:0] : fpat;
               d.bin = hit ? (hidx + 4'h1) : BIN_BAND_MISS;
            end
            if (!hit && !d.comp_fail) begin
               d.comp_fail = 1'b1;
               d.comp_pat  = tpat;
            end
            if (q.ctrl[C_SORT] || !q.ctrl[C_END]) begin
               d.pattern = tpat;
            end else if (q.last) begin
               d.pattern = d.comp_fail ? d.comp_pat : q.pass_pat[PATW-1:0];
            end
            d.last_pass   = hit;
            d.seq_open    = !q.last;
            d.state       = S_DONE;
            d.test_done_n = 1'b0;
            iset[I_DONE]  = 1'b1;
            iset[I_FAIL]  = !hit;
         end
         S_DONE: begin
            d.state       = S_IDLE;
            d.busy_n      = 1'b1;
            d.test_done_n = 1'b1;
         end
      endcase

      if (cap_w) begin
         d.state  = S_JUDGE;
         d.busy_n = 1'b0;
         d.val    = sel_w - ofs_term_w;
         d.last   = i_meas_last;
         if (q.ctrl[C_ACLR] && !q.seq_open) begin
            d.comp_fail = 1'b0;
            d.comp_pat  = '0;
            d.pattern   = '0;
         end
      end

      // Hardware set wins over a simultaneous write-one clear.
      d.istat   = (q.istat & ~w1c) | iset;
      d.irq     = |(d.istat & d.imask);
      d.dio_out = pin_out_w;
      d.dio_oe  = pin_oe_w;
   end

   always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         q <= REGS_RST;
      end else begin
         q <= d;
      end
   end

   assign o_avs_readdata       = q.rdata;
   assign o_avs_waitrequest    = q.waitreq;
   assign o_digital_io_port    = q.dio_out;
   assign o_digital_io_port_oe = q.dio_oe;
   assign o_irq                = q.irq;

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!rst_n_q);

   off_stays_idle_a: assert property ((q.state == S_IDLE) && !q.ctrl[C_EN] |=> q.state == S_IDLE)
      else $error("Disabled unit left idle.");
   auto_clear_a: assert property (cap_w && q.ctrl[C_ACLR] && !q.seq_open |=> !q.comp_fail && (q.pattern == '0))
      else $error("Auto clear did not clear result.");
   end_hold_a: assert property ((q.state == S_JUDGE) && !q.ctrl[C_SORT] && q.ctrl[C_END] && !q.last && !clr_w
                                |=> $stable(q.pattern))
      else $error("End update changed pattern early.");
   offset_sub_a: assert property (cap_w |=> q.val == ($past(sel_w) - $past(ofs_term_w)))
      else $error("Judged value is not feed minus offset.");
   done_pulse_a: assert property ((q.state == S_JUDGE) |=> !q.test_done_n && !q.busy_n ##1 q.test_done_n)
      else $error("Done pulse not one cycle.");
   pin_func_a: assert property ((o_digital_io_port_oe & ~$past(q.diofn[NPIN-1:0])) == 8'h00)
      else $error("Pin driven without digital function.");
   bin_hit_a: assert property ((q.state == S_JUDGE) && (|inband_w)
                               |=> (q.bin >= 4'h1) && (q.bin <= 4'hC)
                               && ((($past(inband_w) >> (q.bin - 4'h1)) & 12'h001) != 12'h000))
      else $error("Bin does not match a passing entry.");
   sort_miss_a: assert property ((q.state == S_JUDGE) && q.ctrl[C_SORT] && !(|inband_w) |=> q.bin == 4'hF)
      else $error("Sort miss bin wrong.");
   band_miss_a: assert property ((q.state == S_JUDGE) && !q.ctrl[C_SORT] && !(|inband_w) |=> q.bin == 4'h0)
      else $error("Band miss bin wrong.");
   sort_pass_a: assert property ((q.state == S_JUDGE) && q.ctrl[C_SORT] && inband_w[0] && !clr_w
                                 |=> q.pattern == $past(q.tcfg[0][T_PASS +: PATW]))
      else $error("Sort pass pattern wrong.");
   // Entry zero is the lowest, so in band mode without end update, when it is enabled and nothing passes its pattern must be the one shown.
   upper_fail_a: assert property ((q.state == S_JUDGE) && !q.ctrl[C_SORT] && !q.ctrl[C_END]
                                  && !(|inband_w) && en_w[0] && above_w[0] && !clr_w
                                  |=> q.pattern == $past(q.tcfg[0][T_UPP +: PATW]))
      else $error("Upper fail pattern wrong.");
   lower_fail_a: assert property ((q.state == S_JUDGE) && !q.ctrl[C_SORT] && !q.ctrl[C_END]
                                  && !(|inband_w) && en_w[0] && below_w[0] && !clr_w
                                  |=> q.pattern == $past(q.tcfg[0][T_LOWP +: PATW]))
      else $error("Lower fail pattern wrong.");
   edge_in_a: assert property (en_w[0] && ((q.val == q.tup[0]) || (q.val == q.tlow[0]))
                               |-> !(above_w[0] && (q.val == q.tup[0])) && !(below_w[0] && (q.val == q.tlow[0])))
      else $error("Value on limit judged as failure.");
endmodule : ltb_top

// ==== ltb_pkg.sv ====
// Constants and types shared by the limit test binning block.
package ltb_pkg;
   localparam int NIDX = 12;
   localparam int PATW = 7;
   localparam int NPIN = 8;
   // Register byte offsets.
   localparam logic [7:0] O_CTRL = 8'h00;
   localparam logic [7:0] O_PINS = 8'h04;
   localparam logic [7:0] O_DIOFN = 8'h08;
   localparam logic [7:0] O_PASS = 8'h0C;
   localparam logic [7:0] O_FAIL = 8'h10;
   localparam logic [7:0] O_OFS = 8'h14;
   localparam logic [7:0] O_STAT = 8'h18;
   localparam logic [7:0] O_ISTAT = 8'h1C;
   localparam logic [7:0] O_IMASK = 8'h20;
   localparam logic [7:0] O_CMD = 8'h24;
   localparam logic [7:0] O_TBL = 8'h40;
   localparam logic [1:0] TW_CFG = 2'h0;
   localparam logic [1:0] TW_UP = 2'h1;
   localparam logic [1:0] TW_LOW = 2'h2;
   // Control word fields.
   localparam int C_EN = 0;
   localparam int C_SORT = 1;
   localparam int C_ACLR = 2;
   localparam int C_END = 3;
   localparam int C_OFS = 4;
   localparam int C_FEED = 5;
   // Pin assignment fields, three bits each.
   localparam int P_FIRST = 0;
   localparam int P_CNT = 4;
   localparam int P_BUSY = 8;
   localparam int P_START = 12;
   localparam int P_DONE = 16;
   // Limit entry configuration fields.
   localparam int T_EN = 0;
   localparam int T_PASS = 4;
   localparam int T_UPP = 12;
   localparam int T_LOWP = 20;
   // Status fields.
   localparam int S_BIN = 0;
   localparam int S_BUSY = 4;
   localparam int S_FAIL = 5;
   localparam int S_PASS = 6;
   localparam int S_PAT = 8;
   // Interrupt and command bits.
   localparam int I_DONE = 0;
   localparam int I_FAIL = 1;
   localparam int K_CLR = 0;
   // Writable bit masks.
   localparam logic [31:0] M_CTRL = 32'h0000_00FF;
   localparam logic [31:0] M_PINS = 32'h0007_7777;
   localparam logic [31:0] M_DIOFN = 32'h0000_00FE;
   localparam logic [31:0] M_PAT = 32'h0000_007F;
   localparam logic [31:0] M_TCFG = 32'h07F7_F7F1;
   localparam logic [31:0] M_IRQ = 32'h0000_0003;
   localparam logic [31:0] M_ALL = 32'hFFFF_FFFF;
   // Reset value of every software register.
   localparam logic [31:0] RST_REG = 32'h0000_0000;
   // Bin codes for a result outside every bin.
   localparam logic [3:0] BIN_BAND_MISS = 4'h0;
   localparam logic [3:0] BIN_SORT_MISS = 4'hF;
   // Feed selection codes.
   localparam logic [2:0] F_AMPS = 3'h0;
   localparam logic [2:0] F_COUL = 3'h1;
   localparam logic [2:0] F_VOLT = 3'h2;
   localparam logic [2:0] F_OHMS = 3'h3;
   localparam logic [2:0] F_MATH = 3'h4;
   typedef enum logic [3:0] {
      S_IDLE  = 4'h1,
      S_WAIT  = 4'h2,
      S_JUDGE = 4'h4,
      S_DONE  = 4'h8
   } ltb_state_t;
endpackage : ltb_pkg

// ==== ltb_handler.sv ====
// Handler model that asks for a test by pulling the start line low.
`timescale 1ns/10ps
module ltb_handler #(
   parameter int START_PIN = 6
) (
   // Clock and request from the bench
   input  wire logic       i_ref_clk,
   input  wire logic       i_go,
   // Levels the handler puts on the port
   output logic      [7:0] o_drive
);
   // Lines the handler leaves alone sit high through pull-ups.
   initial o_drive = 8'hFF;
   always @(posedge i_ref_clk) begin
      o_drive[START_PIN] <= !i_go;
   end
endmodule : ltb_handler

// ==== ltb_top_tb.sv ====
// Self-checking bench for the limit test judgement unit.
`timescale 1ns/10ps
module ltb_top_tb;
   import ltb_pkg::*;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wd = 32'h0;
   logic        mv = 1'b0;
   logic        ml = 1'b0;
   logic        go = 1'b0;
   logic [31:0] feed [5] = '{default: 32'h0};
   logic [31:0] rdat, r, seed;
   logic [7:0]  dout, doe, hdrv, pins;
   logic        wreq, irq;
   logic [6:0]  pp [NIDX], up [NIDX], lp [NIDX], xp;
   logic [3:0]  xb, cap;
   int          lo [NIDX], hi [NIDX];
   int          failures = 0;
   int          tests_run = 0;
   int          vals [9] = '{25, 0, 50, 51, 120, 220, -1, 1150, 2000};

   always #2.5 clk = ~clk;
   assign pins = (doe & dout) | (~doe & hdrv);

   ltb_top dut_u (.i_ref_clk(clk), .i_arst_n(arst_n), .i_avs_address(addr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdat),
      .o_avs_waitrequest(wreq), .i_meas_valid(mv), .i_meas_last(ml), .i_amps(feed[0]),
      .i_coul(feed[1]), .i_volts(feed[2]), .i_ohms(feed[3]), .i_math(feed[4]),
      .i_digital_io_port(pins), .o_digital_io_port(dout), .o_digital_io_port_oe(doe), .o_irq(irq));
   ltb_handler #(.START_PIN(6)) hnd_u (.i_ref_clk(clk), .i_go(go), .o_drive(hdrv));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic results();
      $display("Comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : results

   // One Avalon access; read data lands in r.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      @(posedge clk);
      while (wreq !== 1'b0) begin
         n++;
         if (n > 50) begin
            failures++;
            results();
         end
         @(posedge clk);
      end
      r = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus

   task automatic wait_pin(input int p, input logic lvl);
      int n;
      n = 0;
      while (pins[p] !== lvl) begin
         n++;
         if (n > 100) begin
            failures++;
            results();
         end
         @(posedge clk);
      end
   endtask : wait_pin

   // A value is fed on feed f only once the handler has seen busy go low.
   task automatic run(input int v, input int f, input logic last);
      @(posedge clk);
      go <= 1'b1;
      repeat (2) @(posedge clk);
      go <= 1'b0;
      wait_pin(5, 1'b0);
      for (int n = 0; n < 5; n++) begin
         seed = lfsr(seed);
         feed[n] <= (n == f) ? 32'(v) : seed;
      end
      mv <= 1'b1;
      ml <= last;
      @(posedge clk);
      mv <= 1'b0;
      wait_pin(7, 1'b0);
      cap = pins[4:1];
      @(posedge clk);
      check("done pulse", pins[7], 1'b1);
      wait_pin(5, 1'b1);
   endtask : run

   function automatic void judge(input int v, input logic srt);
      int h;
      int f;
      h = -1;
      f = -1;
      for (int k = 0; k < NIDX; k++) begin
         if (k != 1) begin
            if (v >= lo[k] && v <= hi[k]) begin
               if (h < 0) h = k;
            end else if (f < 0) f = k;
         end
      end
      xb = (h >= 0) ? 4'(h + 1) : (srt ? BIN_SORT_MISS : BIN_BAND_MISS);
      if (h >= 0) xp = srt ? pp[h] : 7'h5A;
      else if (srt) xp = 7'h25;
      else if (f < 0) xp = 7'h00;
      else xp = (v > hi[f]) ? up[f] : lp[f];
   endfunction : judge

   task automatic outcome();
      check("pattern pins", cap, xp[3:0]);
      bus(1'b0, O_STAT, 32'h0);
      check("bin", r[3:0], xb);
      check("pattern", r[14:8], xp);
   endtask : outcome

   initial begin
      seed = 32'hE574;
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      bus(1'b1, 8'h30, 32'hFFFF_FFFF);
      for (int a = 0; a <= 8'h30; a += 4) begin
         bus(1'b0, 8'(a), 32'h0);
         check("reset value", r, RST_REG);
      end
      bus(1'b1, O_PINS, 32'h0007_6541);
      repeat (2) @(posedge clk);
      check("oe trigger fn", doe, 8'h00);
      bus(1'b1, O_DIOFN, 32'h0000_00FE);
      repeat (2) @(posedge clk);
      check("oe", doe, 8'hBE);
      for (int k = 0; k < NIDX; k++) begin
         lo[k] = k * 100;
         hi[k] = k * 100 + 50;
         pp[k] = 7'(k + 1);
         up[k] = 7'(8'h51 + k);
         lp[k] = 7'(8'h3F - k);
         bus(1'b1, 8'(O_TBL + 16 * k), {5'h0, lp[k], 1'b0, up[k], 1'b0, pp[k], 3'h0, 1'(k != 1)});
         bus(1'b1, 8'(O_TBL + 16 * k + 4), 32'(hi[k]));
         bus(1'b1, 8'(O_TBL + 16 * k + 8), 32'(lo[k]));
      end
      bus(1'b1, O_PASS, 32'h0000_005A);
      bus(1'b1, O_FAIL, 32'h0000_0025);
      for (int s = 0; s < 2; s++) begin
         for (int i = 0; i < 9; i++) begin
            bus(1'b1, O_CTRL, 32'(1 + 2 * s + 32 * (i % 5)));
            run(vals[i], i % 5, 1'b1);
            judge(vals[i], 1'(s));
            outcome();
         end
      end
      bus(1'b0, O_ISTAT, 32'h0);
      check("irq status", r, 32'h0000_0003);
      check("irq masked", irq, 1'b0);
      bus(1'b1, O_IMASK, 32'h0000_0001);
      repeat (2) @(posedge clk);
      check("irq raised", irq, 1'b1);
      bus(1'b1, O_ISTAT, 32'h0000_0003);
      repeat (2) @(posedge clk);
      check("irq cleared", irq, 1'b0);
      bus(1'b1, O_OFS, 32'hFFFF_FF9C);
      bus(1'b1, O_CTRL, 32'h0000_0011);
      run(125, 0, 1'b1);
      judge(225, 1'b0);
      outcome();
      bus(1'b1, O_CTRL, 32'h0000_000D);
      run(51, 0, 1'b0);
      check("cleared pins", cap, 4'h0);
      run(25, 0, 1'b1);
      check("end pattern", cap, up[0][3:0]);
      bus(1'b1, O_CMD, 32'h0000_0001);
      bus(1'b0, O_STAT, 32'h0);
      check("clear cmd", r[14:8], 7'h00);
      results();
   end
endmodule : ltb_top_tb
